// File: verilog/fpl_fault.sv
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
// How it works
// RULE_01: Auto restart raises second vector-4 interrupt.
// RULE_02: Halt word at vector halts, lights lamp.
// RULE_03: Set-control code 04 rearms, frees lower levels.
// RULE_04: Panel preset acts like set-control 04.
// RULE_05: Held preset in operate forces halt.
// RULE_06: Software places halt word when no handler.
// RULE_07: Software keeps power routines short.
// RULE_08: Writes generate odd parity bit.
// RULE_09: Reads flag even one-count as error.
// RULE_10: Halt setting halts, lamp until preset.
// RULE_11: Interrupt setting with enable gives vector 5.
// RULE_12: Otherwise parity error only lights lamp.
// RULE_13: Parity error loads failing address.
// RULE_14: Interrupts drop protection unless I/O vector.
// RULE_15: Page protect follows protection enable.
// RULE_16: Page instructions privileged; violation interrupts.
// RULE_17: Page violation sets code 05 flag.
// RULE_18: Output to 05 loads fence, below protected.
// RULE_19: Protected writes, jumps, I/O cause vector 5.
// RULE_20: Bit 15 tells parity from protect.
// RULE_21: Power-fail interrupt highest, never masked.
// RULE_22: Parity enable only by flag on 05.
// RULE_23: Code 04 flag marks restart interrupt.
module fpl_fault (
	input  wire logic            CLK_SYS,
	input  wire logic            RST_N,
	input  wire logic            PWR_FAIL,
	input  wire logic            PWR_OK,
	input  wire logic            RESTART_OPTION_SWITCH,
	input  wire logic            PARITY_ACTION_SWITCH,
	input  wire logic            PROTECT_PRESENT,
	input  wire logic            PANEL_PRESET,
	input  wire logic            KEY_OPERATE,
	input  wire fpl_pkg::fpl_io_t  IO_REQ,
	input  wire fpl_pkg::fpl_mem_t MEM_BUS,
	input  wire logic            VEC_FETCH,
	input  wire logic [14:0]     VEC_ADDR,
	input  wire logic [15:0]     VEC_WORD,
	input  wire logic            VEC_IS_IO,
	input  wire logic            INSTR_VALID,
	input  wire logic [14:0]     INSTR_PC,
	input  wire logic            INSTR_MODIFY,
	input  wire logic            INSTR_JUMP,
	input  wire logic            INSTR_PRIV_MAP,
	input  wire logic [14:0]     INSTR_EA,
	input  wire logic            MAP_LOAD,
	input  wire logic [4:0]      MAP_PAGE,
	input  wire logic [1:0]      MAP_RW_PROT,
	output logic                 PWR_IRQ,
	output logic                 PROT_IRQ,
	output logic                 INHIBIT_LOWER,
	output logic                 HALT_REQ,
	output logic                 EXEC_INHIBIT,
	output logic                 SKIP,
	output logic [15:0]          IO_RDATA,
	output logic                 MEM_PAR_OUT,
	output logic                 PARITY_ERR,
	output logic                 PWR_FAIL_LAMP,
	output logic                 PARITY_LAMP
);
	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [1:0] pf_s_q, ok_s_q, pre_s_q, ars_s_q, pas_s_q, prp_s_q, key_s_q;
	logic pf_q, ok_q, pre_q, ars_q, pas_q, prp_q, key_q, pf_prev_q, ok_prev_q;

	always_ff @(posedge CLK_SYS) begin
		pf_s_q  <= {pf_s_q[0], PWR_FAIL};
		ok_s_q  <= {ok_s_q[0], PWR_OK};
		pre_s_q <= {pre_s_q[0], PANEL_PRESET};
		ars_s_q <= {ars_s_q[0], RESTART_OPTION_SWITCH};
		pas_s_q <= {pas_s_q[0], PARITY_ACTION_SWITCH};
		prp_s_q <= {prp_s_q[0], PROTECT_PRESENT};
		key_s_q <= {key_s_q[0], KEY_OPERATE};
	end

	assign pf_q  = pf_s_q[1];
	assign ok_q  = ok_s_q[1];
	assign pre_q = pre_s_q[1];
	assign ars_q = ars_s_q[1];
	assign pas_q = pas_s_q[1];
	assign prp_q = prp_s_q[1];
	assign key_q = key_s_q[1];

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			pf_prev_q <= 1'b0;
			ok_prev_q <= 1'b0;
		end else begin
			pf_prev_q <= pf_q;
			ok_prev_q <= ok_q;
		end
	end

	// ************************************************************
	// I/O instruction decode
	// ************************************************************
	wire io_pwr   = IO_REQ.valid && IO_REQ.sc == fpl_pkg::SC_PWR;
	wire io_prot  = IO_REQ.valid && IO_REQ.sc == fpl_pkg::SC_PROT;
	wire stc_pwr  = io_pwr && IO_REQ.op == fpl_pkg::IO_SET_CTL;
	wire stc_prot = io_prot && IO_REQ.op == fpl_pkg::IO_SET_CTL;
	wire stf_prot = io_prot && IO_REQ.op == fpl_pkg::IO_SET_FLG;
	wire clf_prot = io_prot && IO_REQ.op == fpl_pkg::IO_CLR_FLG;
	wire out_prot = io_prot && IO_REQ.op == fpl_pkg::IO_OUT;
	wire in_prot  = io_prot && IO_REQ.op == fpl_pkg::IO_IN;
	wire skip_op  = IO_REQ.op == fpl_pkg::IO_SKIP_SET || IO_REQ.op == fpl_pkg::IO_SKIP_CLR;
	wire skip_hi  = IO_REQ.op == fpl_pkg::IO_SKIP_SET;
	wire rearm    = stc_pwr || pre_q;  // RULE_03 RULE_04

	// ************************************************************
	// Power-fail sequencer
	// ************************************************************
	typedef enum logic [2:0] {
		PS_ARMED,
		PS_DOWN,
		PS_WAIT_OK,
		PS_DELAY,
		PS_UP
	} fpl_pstate_t;

	fpl_pstate_t ps_q, ps_d;
	logic [26:0] dly_q, dly_d;
	logic        restart_flag_q, restart_flag_d;
	logic        pwr_irq_q, pwr_irq_d;

	wire pf_rise  = pf_q && !pf_prev_q;
	wire dly_done = dly_q == 27'(fpl_pkg::RESTART_TICKS - 1);

	always_comb begin
		ps_d           = ps_q;
		dly_d          = dly_q;
		restart_flag_d = restart_flag_q;
		pwr_irq_d      = 1'b0;
		case (ps_q)
			PS_ARMED: begin
				if (pf_rise) begin  // RULE_21
					pwr_irq_d      = 1'b1;
					restart_flag_d = 1'b0;
					ps_d           = PS_DOWN;
				end
			end
			PS_DOWN: begin
				if (!ok_q) begin
					ps_d = PS_WAIT_OK;
				end
			end
			PS_WAIT_OK: begin
				if (ok_q && !ok_prev_q && ars_q) begin
					dly_d = '0;
					ps_d  = PS_DELAY;
				end
			end
			PS_DELAY: begin
				dly_d = dly_q + 27'h0000001;
				if (dly_done) begin  // RULE_01
					pwr_irq_d      = 1'b1;
					restart_flag_d = 1'b1;  // RULE_23
					ps_d           = PS_UP;
				end
			end
			PS_UP: begin
			end
			default: ps_d = PS_ARMED;
		endcase
		if (rearm) begin  // RULE_03 RULE_04
			ps_d = PS_ARMED;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			ps_q           <= PS_ARMED;
			dly_q          <= '0;
			restart_flag_q <= 1'b0;
			pwr_irq_q      <= 1'b0;
		end else begin
			ps_q           <= ps_d;
			dly_q          <= dly_d;
			restart_flag_q <= restart_flag_d;
			pwr_irq_q      <= pwr_irq_d;
		end
	end

	// ************************************************************
	// Parity generation and check
	// ************************************************************
	logic wr_par, rd_bad;

	fpl_parity u_par (
		.wr_data (MEM_BUS.data),
		.rd_data (MEM_BUS.data),
		.rd_par  (MEM_BUS.par),
		.wr_par  (wr_par),
		.rd_bad  (rd_bad)
	);

	wire par_err = MEM_BUS.rd && rd_bad;  // RULE_09

	// ************************************************************
	// Protection state
	// ************************************************************
	logic        prot_en_q, par_en_q, flag05_q;
	logic [14:0] fence_q;
	logic [15:0] viol_q;
	logic [1:0]  page_bits;

	fpl_page_mem u_pages (
		.clk     (CLK_SYS),
		.we      (MAP_LOAD),
		.wr_page (MAP_PAGE),
		.wr_bits (MAP_RW_PROT),
		.rd_page (INSTR_EA[fpl_pkg::ADDR_W-1:fpl_pkg::PAGE_LSB]),
		.rd_bits (page_bits)
	);

	// Page bits arrive a cycle late, so the access is held one cycle
	logic        acc_v_q, acc_mod_q;
	logic [14:0] acc_pc_q;

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			acc_v_q   <= 1'b0;
			acc_mod_q <= 1'b0;
			acc_pc_q  <= '0;
		end else begin
			acc_v_q   <= INSTR_VALID && prot_en_q;
			acc_mod_q <= INSTR_MODIFY;
			acc_pc_q  <= INSTR_PC;
		end
	end

	wire fence_hit = INSTR_EA < fence_q;  // RULE_18
	wire io_bad    = IO_REQ.valid && IO_REQ.sc != fpl_pkg::SC_PROC;
	wire mp_viol   = prot_en_q && INSTR_VALID && (((INSTR_MODIFY || INSTR_JUMP) && fence_hit) || io_bad);  // RULE_19
	wire map_page  = acc_v_q && (acc_mod_q ? page_bits[1] : page_bits[0]);  // RULE_15
	wire map_priv  = prot_en_q && INSTR_VALID && INSTR_PRIV_MAP;  // RULE_16
	wire map_viol  = map_page || map_priv;
	wire par_int   = par_err && !pas_q && prp_q && par_en_q;  // RULE_11 RULE_12
	wire vec_any   = VEC_FETCH && !VEC_IS_IO;  // RULE_14

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			prot_en_q <= 1'b0;
			par_en_q  <= 1'b0;
			flag05_q  <= 1'b0;
			fence_q   <= '0;
			viol_q    <= '0;
		end else begin
			if (vec_any || mp_viol || map_viol) begin
				prot_en_q <= 1'b0;  // RULE_14
			end else if (stc_prot) begin
				prot_en_q <= 1'b1;  // RULE_14 RULE_15
			end
			if (stf_prot) begin
				par_en_q <= 1'b1;  // RULE_22
			end else if (clf_prot) begin
				par_en_q <= 1'b0;  // RULE_22
			end
			if (map_viol) begin
				flag05_q <= 1'b1;  // RULE_17
			end else if (clf_prot || stc_prot) begin
				flag05_q <= 1'b0;
			end
			if (out_prot) begin
				fence_q <= IO_REQ.data[14:0];  // RULE_18
			end
			if (par_err) begin
				viol_q <= {1'b1, MEM_BUS.addr};  // RULE_13 RULE_20
			end else if (mp_viol) begin
				viol_q <= {1'b0, INSTR_PC};  // RULE_20
			end else if (map_page) begin
				viol_q <= {1'b0, acc_pc_q};
			end
		end
	end

	// ************************************************************
	// Halt and lamps
	// ************************************************************
	logic pf_lamp_q, par_lamp_q, halt_q, inh_q, prot_irq_q, exec_inh_q;
	logic skip_q, par_out_q, par_err_q;
	logic [15:0] rdata_q;

	wire halt_vec = VEC_FETCH && VEC_ADDR == fpl_pkg::VEC_PWR
		&& VEC_WORD == fpl_pkg::HALT_PWR_WD;  // RULE_02

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			pf_lamp_q  <= 1'b0;
			par_lamp_q <= 1'b0;
			halt_q     <= 1'b0;
			inh_q      <= 1'b0;
			prot_irq_q <= 1'b0;
			exec_inh_q <= 1'b0;
			skip_q     <= 1'b0;
			par_out_q  <= 1'b0;
			par_err_q  <= 1'b0;
			rdata_q    <= '0;
		end else begin
			if (halt_vec) begin
				pf_lamp_q <= 1'b1;  // RULE_02
			end else if (pre_q) begin
				pf_lamp_q <= 1'b0;
			end
			if (par_err) begin
				par_lamp_q <= 1'b1;  // RULE_10 RULE_12
			end else if (pre_q) begin
				par_lamp_q <= 1'b0;  // RULE_10
			end
			halt_q     <= (pre_q && key_q) || halt_vec || (par_err && pas_q);  // RULE_05 RULE_10
			if (pwr_irq_d) begin
				inh_q <= 1'b1;
			end else if (rearm) begin
				inh_q <= 1'b0;  // RULE_03
			end
			prot_irq_q <= mp_viol || map_viol || par_int;  // RULE_16 RULE_19
			exec_inh_q <= mp_viol || map_priv;  // RULE_19
			if (io_pwr && skip_op) begin
				skip_q <= restart_flag_q == skip_hi;  // RULE_23
			end else if (io_prot && skip_op) begin
				skip_q <= flag05_q == skip_hi;  // RULE_17
			end else begin
				skip_q <= 1'b0;
			end
			par_out_q  <= wr_par;  // RULE_08
			par_err_q  <= par_err;
			rdata_q    <= in_prot ? viol_q : '0;  // RULE_13
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign PWR_IRQ       = pwr_irq_q;
	assign PROT_IRQ      = prot_irq_q;
	assign INHIBIT_LOWER = inh_q;
	assign HALT_REQ      = halt_q;
	assign EXEC_INHIBIT  = exec_inh_q;
	assign SKIP          = skip_q;
	assign IO_RDATA      = rdata_q;
	assign MEM_PAR_OUT   = par_out_q;
	assign PARITY_ERR    = par_err_q;
	assign PWR_FAIL_LAMP = pf_lamp_q;
	assign PARITY_LAMP   = par_lamp_q;
endmodule

// File: verilog/fpl_pkg.sv
package fpl_pkg;

	// ************************************************************
	// I/O select codes and vectors
	// ************************************************************
	localparam logic [5:0]  SC_PROC     = 6'h01;
	localparam logic [5:0]  SC_PWR      = 6'h04;
	localparam logic [5:0]  SC_PROT     = 6'h05;
	localparam logic [14:0] VEC_PWR     = 15'h0004;
	localparam logic [14:0] VEC_PROT    = 15'h0005;
	localparam logic [15:0] HALT_PWR_WD = 16'h8404;  // 102004 octal

	// ************************************************************
	// Field positions and widths
	// ************************************************************
	localparam int DATA_W    = 16;
	localparam int ADDR_W    = 15;
	localparam int VIOL_KIND = 15;
	localparam int PAGE_LSB  = 10;
	localparam int PAGE_W    = ADDR_W - PAGE_LSB;
	localparam int PAGES     = 32;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam longint CLK_HZ        = 200000000;
	localparam longint RESTART_MS    = 500;
	localparam longint RESTART_TICKS = CLK_HZ / 1000 * RESTART_MS;
	localparam int     CNT_W         = 27;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [2:0] {
		IO_SET_CTL,
		IO_CLR_CTL,
		IO_SET_FLG,
		IO_CLR_FLG,
		IO_SKIP_SET,
		IO_SKIP_CLR,
		IO_OUT,
		IO_IN
	} fpl_io_op_t;

	typedef struct packed {
		logic       valid;
		fpl_io_op_t op;
		logic [5:0] sc;
		logic [15:0] data;
	} fpl_io_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [14:0] addr;
		logic [15:0] data;
		logic        par;
	} fpl_mem_t;

endpackage

// File: verilog/fpl_parity.sv
`timescale 1ns/1ps
// Odd parity generator and checker
module fpl_parity (
	input  wire logic [15:0] wr_data,
	input  wire logic [15:0] rd_data,
	input  wire logic        rd_par,
	output logic             wr_par,
	output logic             rd_bad
);
	// ************************************************************
	// Parity
	// ************************************************************
	assign wr_par = ~(^wr_data);         // RULE_08
	assign rd_bad = ~(^{rd_data, rd_par}); // RULE_09
endmodule

// File: verilog/fpl_page_mem.sv
`timescale 1ns/1ps
// Per-page read/write protect bits
module fpl_page_mem (
	input  wire logic       clk,
	input  wire logic       we,
	input  wire logic [4:0] wr_page,
	input  wire logic [1:0] wr_bits,
	input  wire logic [4:0] rd_page,
	output logic      [1:0] rd_bits
);
	logic [1:0] mem [0:31];

	// ************************************************************
	// Storage, registered read
	// ************************************************************
	always_ff @(posedge clk) begin
		if (we) begin
			mem[wr_page] <= wr_bits;
		end
		rd_bits <= mem[rd_page];
	end
endmodule

// File: sim/fpl_fault_monitor.sv
`timescale 1ns/1ps
// Port-level checks on the fault block
module fpl_fault_monitor (
	input wire logic              CLK_SYS,
	input wire logic              RST_N,
	input wire logic              PWR_FAIL,
	input wire logic              PARITY_ACTION_SWITCH,
	input wire logic              PANEL_PRESET,
	input wire logic              KEY_OPERATE,
	input wire fpl_pkg::fpl_io_t  IO_REQ,
	input wire fpl_pkg::fpl_mem_t MEM_BUS,
	input wire logic              INSTR_VALID,
	input wire logic              PWR_IRQ,
	input wire logic              PROT_IRQ,
	input wire logic              INHIBIT_LOWER,
	input wire logic              HALT_REQ,
	input wire logic              EXEC_INHIBIT,
	input wire logic              MEM_PAR_OUT,
	input wire logic              PARITY_ERR,
	input wire logic              PARITY_LAMP
);
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);
	// Preset held long enough to pass the synchronisers
	sequence s_preset_op;
		(PANEL_PRESET && KEY_OPERATE) [*4];
	endsequence
	sequence s_preset_only;
		(PANEL_PRESET && !PWR_FAIL) [*4];
	endsequence
	sequence s_lamp_quiet;
		(!PANEL_PRESET) [*4] ##0 PARITY_LAMP;
	endsequence
	a_wr_parity: assert property (MEM_BUS.wr |=> MEM_PAR_OUT == ~^$past(MEM_BUS.data))
		else $error("write parity bit wrong");
	a_rd_check: assert property (MEM_BUS.rd |=> PARITY_ERR == ~^$past({MEM_BUS.data, MEM_BUS.par}))
		else $error("read parity error flag wrong");
	a_par_halt: assert property ($past(PARITY_ACTION_SWITCH, 3) && PARITY_ACTION_SWITCH && MEM_BUS.rd
		&& !(^{MEM_BUS.data, MEM_BUS.par}) |=> HALT_REQ && PARITY_LAMP)
		else $error("parity halt missing");
	a_lamp_hold: assert property (s_lamp_quiet |=> PARITY_LAMP)
		else $error("parity lamp dropped without preset");
	a_preset_halt: assert property (s_preset_op |-> HALT_REQ)
		else $error("held preset did not halt");
	a_preset_rearm: assert property (s_preset_only |=> !INHIBIT_LOWER)
		else $error("preset did not free lower levels");
	a_pwr_irq: assert property ($rose(PWR_FAIL) |-> ##[1:5] PWR_IRQ)
		else $error("power fail interrupt missing");
	a_inhibit_irq: assert property (EXEC_INHIBIT |-> PROT_IRQ && $past(INSTR_VALID))
		else $error("inhibit without cause or interrupt");
	a_io_sc01: assert property (INSTR_VALID && IO_REQ.valid && IO_REQ.sc == fpl_pkg::SC_PROC
		|=> !EXEC_INHIBIT)
		else $error("select code 01 was inhibited");
endmodule

bind fpl_fault fpl_fault_monitor mon (.CLK_SYS, .RST_N, .PWR_FAIL, .PARITY_ACTION_SWITCH, .PANEL_PRESET,
	.KEY_OPERATE, .IO_REQ, .MEM_BUS, .INSTR_VALID, .PWR_IRQ, .PROT_IRQ, .INHIBIT_LOWER, .HALT_REQ,
	.EXEC_INHIBIT, .MEM_PAR_OUT, .PARITY_ERR, .PARITY_LAMP);

// File: sim/fpl_mem_model.sv
`timescale 1ns/1ps
// Main memory beside the fault block, 64 words deep
module fpl_mem_model (
	input  wire logic              clk,
	input  wire fpl_pkg::fpl_mem_t req,
	input  wire logic              par_in,
	input  wire logic              corrupt,
	output fpl_pkg::fpl_mem_t      bus
);
	logic [16:0] mem_q [64];
	logic        wr_q;
	logic [5:0]  wa_q;
	logic [15:0] wd_q;
	logic        tog_q = 1'b0;
	// Store word with the parity bit the block returns a cycle later
	always_ff @(posedge clk) begin
		tog_q <= ~tog_q;
		wr_q  <= req.wr;
		wa_q  <= req.addr[5:0];
		wd_q  <= req.data;
		if (wr_q) begin
			mem_q[wa_q] <= {wd_q, par_in};
		end
	end
	// Reads return the stored word, idle lines toggle
	assign bus.rd   = req.rd;
	assign bus.wr   = req.wr;
	assign bus.addr = req.addr;
	assign bus.data = req.rd ? mem_q[req.addr[5:0]][16:1] : (req.wr ? req.data : {16{tog_q}});
	assign bus.par  = req.rd ? mem_q[req.addr[5:0]][0] ^ corrupt : tog_q; // Flip on command
endmodule

// File: sim/fpl_tb.sv
`timescale 1ns/1ps
// Processor-side bench for the fault block
module tb;
	logic clk = 1'b0, rst_n = 1'b0, pf = 1'b0, pok = 1'b1, rsw = 1'b0, psw = 1'b0, pp = 1'b1;
	logic pre = 1'b0, key = 1'b0, vf = 1'b0, vio = 1'b0, iv = 1'b0, md = 1'b0, jp = 1'b0;
	logic pv = 1'b0, ml = 1'b0, bad = 1'b0;
	logic pirq, prq, inh, halt_instr, xinh, skip, mpar, perr, plamp, parlamp;
	logic [14:0]       va = '0, pc = '0, ea = '0;
	logic [15:0]       vw = '0, rd;
	logic [4:0]        mpg = '0;
	logic [1:0]        mrw = '0;
	logic [15:0]       tbl [4] = '{16'h0000, 16'h0001, 16'hFFFF, 16'h8421};
	fpl_pkg::fpl_io_t  io = '0;
	fpl_pkg::fpl_mem_t mreq = '0, mbus;
	int                err_count = 0, num_checks = 0;

	fpl_mem_model mm (.clk(clk), .req(mreq), .par_in(mpar), .corrupt(bad), .bus(mbus));
	fpl_fault dut (.CLK_SYS(clk), .RST_N(rst_n), .PWR_FAIL(pf), .PWR_OK(pok), .RESTART_OPTION_SWITCH(rsw),
		.PARITY_ACTION_SWITCH(psw), .PROTECT_PRESENT(pp), .PANEL_PRESET(pre), .KEY_OPERATE(key),
		.IO_REQ(io), .MEM_BUS(mbus), .VEC_FETCH(vf), .VEC_ADDR(va), .VEC_WORD(vw), .VEC_IS_IO(vio),
		.INSTR_VALID(iv), .INSTR_PC(pc), .INSTR_MODIFY(md), .INSTR_JUMP(jp), .INSTR_PRIV_MAP(pv),
		.INSTR_EA(ea), .MAP_LOAD(ml), .MAP_PAGE(mpg), .MAP_RW_PROT(mrw), .PWR_IRQ(pirq), .PROT_IRQ(prq),
		.INHIBIT_LOWER(inh), .HALT_REQ(halt_instr), .EXEC_INHIBIT(xinh), .SKIP(skip), .IO_RDATA(rd),
		.MEM_PAR_OUT(mpar), .PARITY_ERR(perr), .PWR_FAIL_LAMP(plamp), .PARITY_LAMP(parlamp));

	always #2.5 clk = ~clk;

	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	// One I/O instruction, answer sampled in the following cycle
	task automatic iop(input fpl_pkg::fpl_io_op_t op, input logic [5:0] sc, input logic [15:0] d);
		@(posedge clk);
		io <= '{1'b1, op, sc, d};
		@(posedge clk);
		io.valid <= 1'b0;
		#1;
	endtask
	task automatic mem(input logic w, input logic [14:0] a, input logic c);
		@(posedge clk);
		mreq <= '{~w, w, a, tbl[a[1:0]], 1'b0};
		bad <= c;
		@(posedge clk);
		mreq.rd <= 1'b0;
		mreq.wr <= 1'b0;
		#1;
	endtask
	task automatic vec(input logic [14:0] a, input logic [15:0] w, input logic i);
		@(posedge clk);
		{vf, va, vw, vio} <= {1'b1, a, w, i};
		@(posedge clk);
		vf <= 1'b0;
		#1;
	endtask
	// Instruction with optional I/O request; interrupt looked for over three cycles
	task automatic ins(input logic m, j, p, input logic [14:0] e, input logic [5:0] sc, input logic i,
		output logic hit, output logic x);
		@(posedge clk);
		{iv, md, jp, pv, ea, pc} <= {1'b1, m, j, p, e, e + 15'h0010};
		io <= '{i, fpl_pkg::IO_OUT, sc, 16'h0000};
		@(posedge clk);
		iv <= 1'b0;
		io.valid <= 1'b0;
		#1;
		hit = prq;
		x = xinh;
		repeat (2) begin
			@(posedge clk);
			#1;
			hit |= prq;
		end
	endtask
	// Preset held past the synchronisers, key position given
	task automatic hold_preset(input logic k);
		@(posedge clk);
		key <= k;
		pre <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk("preset_halt", 16'(k), 16'(halt_instr));
		@(posedge clk);
		pre <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
	endtask
	task automatic pwr(output logic h);
		@(posedge clk);
		pf <= 1'b1;
		h = 1'b0;
		for (int k = 0; k < 8 && !h; k++) begin
			@(posedge clk);
			#1;
			h = pirq;
		end
	endtask

	initial begin
		repeat (100000) @(posedge clk);
		err_count++;
		test_done();
	end

	initial begin
		logic h, x;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		// Every page open except page 2, write-protected
		for (int k = 0; k < 32; k++) begin
			@(posedge clk);
			{ml, mpg, mrw} <= {1'b1, 5'(k), (k == 2) ? 2'b10 : 2'b00};
		end
		@(posedge clk);
		ml <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			mem(1'b1, 15'(k), 1'b0);
			chk("par_out", 16'(~^tbl[k]), 16'(mpar));
			mem(1'b0, 15'(k), 1'b0);
			chk("perr_clean", 16'h0000, 16'(perr));
		end
		iop(fpl_pkg::IO_SET_FLG, 6'h05, 16'h0000);
		mem(1'b0, 15'h0003, 1'b1);
		chk("perr", 16'h0001, 16'(perr));
		chk("par_irq", 16'h0001, 16'(prq));
		iop(fpl_pkg::IO_IN, 6'h05, 16'h0000);
		chk("viol_par", 16'h8003, rd);
		iop(fpl_pkg::IO_CLR_FLG, 6'h05, 16'h0000);
		hold_preset(1'b0);
		mem(1'b0, 15'h0002, 1'b1);
		chk("par_irq_off", 16'h0000, 16'(prq));
		chk("lamp_only", 16'h0001, 16'(parlamp));
		@(posedge clk);
		pp <= 1'b0;
		iop(fpl_pkg::IO_SET_FLG, 6'h05, 16'h0000);
		mem(1'b0, 15'h0002, 1'b1);
		chk("no_prot_hw", 16'h0000, 16'(prq));
		@(posedge clk);
		{pp, psw} <= 2'b11;
		repeat (4) @(posedge clk);
		mem(1'b0, 15'h0001, 1'b1);
		chk("par_halt", 16'h0001, 16'(halt_instr));
		hold_preset(1'b0);
		chk("lamp_clear", 16'h0000, 16'(parlamp));
		@(posedge clk);
		psw <= 1'b0;
		iop(fpl_pkg::IO_OUT, 6'h05, 16'h0100);
		iop(fpl_pkg::IO_SET_CTL, 6'h05, 16'h0000);
		ins(1'b1, 1'b0, 1'b0, 15'h00FF, 6'h00, 1'b0, h, x);
		chk("below_fence", 16'h0001, 16'(x));
		iop(fpl_pkg::IO_IN, 6'h05, 16'h0000);
		chk("viol_prot", 16'h010F, rd);
		iop(fpl_pkg::IO_SKIP_SET, 6'h05, 16'h0000);
		chk("flag_prot", 16'h0000, 16'(skip));
		iop(fpl_pkg::IO_SET_CTL, 6'h05, 16'h0000);
		ins(1'b1, 1'b0, 1'b0, 15'h0100, 6'h00, 1'b0, h, x);
		chk("at_fence", 16'h0000, 16'(x));
		ins(1'b0, 1'b0, 1'b0, 15'h0400, 6'h01, 1'b1, h, x);
		chk("io_sc01", 16'h0000, 16'(x));
		ins(1'b0, 1'b1, 1'b0, 15'h0001, 6'h00, 1'b0, h, x);
		chk("jump_in", 16'h0001, 16'(x));
		iop(fpl_pkg::IO_SET_CTL, 6'h05, 16'h0000);
		ins(1'b0, 1'b0, 1'b0, 15'h0400, 6'h02, 1'b1, h, x);
		chk("io_other", 16'h0001, 16'(x));
		iop(fpl_pkg::IO_SET_CTL, 6'h05, 16'h0000);
		vec(15'h0010, 16'h0000, 1'b1);
		ins(1'b1, 1'b0, 1'b0, 15'h00FF, 6'h00, 1'b0, h, x);
		chk("vec_io_keeps", 16'h0001, 16'(x));
		iop(fpl_pkg::IO_SET_CTL, 6'h05, 16'h0000);
		vec(15'h0010, 16'h0000, 1'b0);
		ins(1'b1, 1'b0, 1'b0, 15'h00FF, 6'h00, 1'b0, h, x);
		chk("vec_drops", 16'h0000, 16'(x));
		iop(fpl_pkg::IO_SET_CTL, 6'h05, 16'h0000);
		ins(1'b1, 1'b0, 1'b0, 15'h0800, 6'h00, 1'b0, h, x);
		chk("page_wprot", 16'h0001, 16'(h));
		iop(fpl_pkg::IO_SKIP_SET, 6'h05, 16'h0000);
		chk("flag_page", 16'h0001, 16'(skip));
		iop(fpl_pkg::IO_SET_CTL, 6'h05, 16'h0000);
		ins(1'b0, 1'b0, 1'b1, 15'h0400, 6'h00, 1'b0, h, x);
		chk("priv_map", 16'h0001, 16'(h));
		pwr(h);
		chk("pwr_irq", 16'h0001, 16'(h));
		iop(fpl_pkg::IO_SKIP_SET, 6'h04, 16'h0000);
		chk("pwr_down", 16'h0000, 16'(skip));
		chk("lower_held", 16'h0001, 16'(inh));
		@(posedge clk);
		pf <= 1'b0;
		iop(fpl_pkg::IO_SET_CTL, 6'h04, 16'h0000);
		chk("rearm", 16'h0000, 16'(inh));
		pwr(h);
		chk("pwr_irq_again", 16'h0001, 16'(h));
		vec(fpl_pkg::VEC_PWR, fpl_pkg::HALT_PWR_WD, 1'b0);
		chk("halt_word", 16'h0001, 16'(halt_instr));
		chk("pwr_lamp", 16'h0001, 16'(plamp));
		@(posedge clk);
		pf <= 1'b0;
		hold_preset(1'b0);
		chk("preset_rearm", 16'h0000, 16'(inh));
		chk("pwr_lamp_clr", 16'h0000, 16'(plamp));
		hold_preset(1'b1);
		test_done();
	end
endmodule
